//--- include/fsa_pkg.sv
// Purpose: Shared types and constants for the fault status aggregator.
// Assumes: One system clock; condition flags arrive asynchronously.
// Notes: Packed structs list fields from bit 31 (or 15, or 8) down to bit 0.
`default_nettype none
package fsa_pkg;

	// ----------------------------------------
	// Status word 0 layout
	// ----------------------------------------
	typedef struct packed {
		logic spare31;
		logic targetUpgrading;
		logic regulationLost;
		logic underMinVoltage;
		logic resistorModuleHot;
		logic inputLineFault;
		logic firmwareStackExceeded;
		logic configMismatch;
		logic diodeModuleHot;
		logic maintenance;
		logic spare21;
		logic interlockOpenFlag;
		logic auxFuseOpen;
		logic linearModuleHot;
		logic terminalVoltageExcess;
		logic terminalCurrentExcess;
		logic commCorrupt;
		logic phaseCurrentExcess;
		logic targetBootWait;
		logic targetBootFail;
		logic resistorPowerLimit;
		logic linearPowerLimit;
		logic shutdown;
		logic lowVoltageTripFlag;
		logic senseLossStatus;
		logic powerTripFlag;
		logic voltageTripFlag;
		logic currentTripFlag;
		logic [1:0] spare3to2;
		logic outputLive;
		logic standby;
	} fsa_stat0_t;

	// ----------------------------------------
	// Status word 1 layout
	// ----------------------------------------
	typedef struct packed {
		logic [13:0] spare31to18;
		logic firmwareMismatch;
		logic badSystemRating;
		logic [7:0] spare15to8;
		logic transformerHot;
		logic outputCapsHot;
		logic outputFilterHot;
		logic powerStageHot;
		logic spare3;
		logic fanStalled;
		logic inputFuseOpen;
		logic phaseMissing;
	} fsa_stat1_t;

	// ----------------------------------------
	// Questionable word layout (fixed forever)
	// ----------------------------------------
	typedef struct packed {
		logic ioInputFaultFlag;
		logic inputPowerLossFlag;
		logic interlockOpenFlag;
		logic hardFaultSummary;
		logic softFaultSummary;
		logic constPowerMode;
		logic constResistanceMode;
		logic constVoltageMode;
		logic constCurrentMode;
		logic senseLossFlag;
		logic hardOvertemp;
		logic hardOvercurrent;
		logic softOverpower;
		logic softOvervoltage;
		logic softOvercurrent;
		logic hardOvervoltage;
	} fsa_ques_t;

	// Conditions seen only by the questionable word
	typedef struct packed {
		logic hardOvervoltage;
		logic hardOvercurrent;
		logic hardOvertemp;
		logic constCurrentMode;
		logic constVoltageMode;
		logic constResistanceMode;
		logic constPowerMode;
		logic inputPowerLossFlag;
		logic ioInputFaultFlag;
	} fsa_qsrc_t;

	// Assigned bits; every other bit is forced low
	localparam logic [31:0] STAT0_USED = 32'h7FDF_FFF3;
	localparam logic [31:0] STAT1_USED = 32'h0003_00F7;
	localparam logic [15:0] QUES_PAD = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic [1:0] {
		QS_QUES = 2'h0,
		QS_INDEX = 2'h1,
		QS_BOTH = 2'h2,
		QS_RSVD = 2'h3
	} fsa_qsel_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SECOND = 2'h1
	} fsa_state_t;

endpackage : fsa_pkg
`default_nettype wire

//--- hw/fsa_fault_status.sv
// Purpose: Live fault/status words of an electronic load, read by query.
// Assumes: Condition flags are asynchronous levels; query port is on sys_clk.
// Notes: Reads never change state; a both-words query answers on two cycles.
// How it works
// - Questionable bits 0,4,5,6 show hard overvoltage, overcurrent, overtemp, sense loss.
// - Questionable bits 1,2,3 show current, voltage and power soft trips.
// - Questionable bits 7 to 10 show constant current, voltage, resistance, power modes.
// - Questionable bit 11 is the OR of all soft trips.
// - Questionable bit 12 is the OR of all hard protections.
// - Questionable bits 13,14,15: interlock open, input power loss, input fault.
// - Indexed query: index 0 gives status word 0, index 1 word 1.
// - All bits are read-only and follow their source live, unlatched.
// - Reading has no side effect; bits keep their values.
// - Questionable word is a fixed subset with constant bit positions.
// - Query without index returns word 0 then word 1.
// - Status 0 bit 0 standby, bit 1 output live.
// - Status 0 bits 4-6 trips, 7 sense loss, 8 undervoltage trip.
// - Status 0 bit 9 shutdown, 10 and 11 linear/resistor power excess.
// - Status 0 bit 12 boot failure, 13 boot waiting.
// - Status 0 bits 16,17 terminal current/voltage excess, 20 interlock.
// - Status 0 bits 18,23,27 linear, diode, resistor module overtemperature.
// - Status 0 bits 14 phase current, 15 comms, 19 aux fuse, 26 line fault.
// - Status 0 bits 22,24,25,28,29,30 maintenance through target upgrade.
// - Status 1 bits 0,1,2 phase missing, input fuse, fan stalled.
// - Status 1 bits 4-7 power stage, filter, caps, transformer temperature.
// - Status 1 bits 16,17 bad rating, firmware mismatch.
`timescale 1ns/10ps
`default_nettype none
module fsa_fault_status
	import fsa_pkg::*;
#(
	parameter int IDX_W = 8
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire fsa_stat0_t stat0Src,
	input wire fsa_stat1_t stat1Src,
	input wire fsa_qsrc_t quesSrc,
	input wire logic queryValid,
	input wire fsa_qsel_t querySel,
	input wire logic [IDX_W-1:0] queryIndex,
	output logic queryReady,
	output logic ansValid,
	output logic ansLast,
	output logic ansError,
	output logic [31:0] ansWord,
	output fsa_ques_t quesWord,
	output fsa_stat0_t statWord0,
	output fsa_stat1_t statWord1
);

	// ----------------------------------------
	// Source synchronisers
	// ----------------------------------------
	fsa_stat0_t s0Meta_reg, s0Sync_reg;
	fsa_stat1_t s1Meta_reg, s1Sync_reg;
	fsa_qsrc_t qMeta_reg, qSync_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			s0Meta_reg <= fsa_stat0_t'(WORD_ZERO);
			s0Sync_reg <= fsa_stat0_t'(WORD_ZERO);
			s1Meta_reg <= fsa_stat1_t'(WORD_ZERO);
			s1Sync_reg <= fsa_stat1_t'(WORD_ZERO);
			qMeta_reg <= '0;
			qSync_reg <= '0;
		end else begin
			s0Meta_reg <= stat0Src;
			s0Sync_reg <= s0Meta_reg;
			s1Meta_reg <= stat1Src;
			s1Sync_reg <= s1Meta_reg;
			qMeta_reg <= quesSrc;
			qSync_reg <= qMeta_reg;
		end
	end

	// ----------------------------------------
	// Word assembly
	// ----------------------------------------
	// Masking here rather than at the sources keeps spare inputs harmless
	fsa_stat0_t stat0_next;
	fsa_stat1_t stat1_next;
	fsa_ques_t ques_next;
	assign stat0_next = fsa_stat0_t'(s0Sync_reg & STAT0_USED);
	assign stat1_next = fsa_stat1_t'(s1Sync_reg & STAT1_USED);

	// Trips and interlock are shared with status word 0 so both views agree
	assign ques_next.hardOvervoltage = qSync_reg.hardOvervoltage;
	assign ques_next.hardOvercurrent = qSync_reg.hardOvercurrent;
	assign ques_next.hardOvertemp = qSync_reg.hardOvertemp;
	assign ques_next.senseLossFlag = stat0_next.senseLossStatus;
	assign ques_next.softOvercurrent = stat0_next.currentTripFlag;
	assign ques_next.softOvervoltage = stat0_next.voltageTripFlag;
	assign ques_next.softOverpower = stat0_next.powerTripFlag;
	assign ques_next.constCurrentMode = qSync_reg.constCurrentMode;
	assign ques_next.constVoltageMode = qSync_reg.constVoltageMode;
	assign ques_next.constResistanceMode = qSync_reg.constResistanceMode;
	assign ques_next.constPowerMode = qSync_reg.constPowerMode;
	assign ques_next.softFaultSummary = stat0_next.currentTripFlag | stat0_next.voltageTripFlag
		| stat0_next.powerTripFlag;
	assign ques_next.hardFaultSummary = qSync_reg.hardOvervoltage | qSync_reg.hardOvercurrent
		| qSync_reg.hardOvertemp | stat0_next.senseLossStatus;
	assign ques_next.interlockOpenFlag = stat0_next.interlockOpenFlag;
	assign ques_next.inputPowerLossFlag = qSync_reg.inputPowerLossFlag;
	assign ques_next.ioInputFaultFlag = qSync_reg.ioInputFaultFlag;

	// ----------------------------------------
	// Live status registers
	// ----------------------------------------
	// No hold term: every bit drops the cycle after its sync stage does, on the third edge after its source goes away
	fsa_stat0_t stat0_reg;
	fsa_stat1_t stat1_reg;
	fsa_ques_t ques_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			stat0_reg <= fsa_stat0_t'(WORD_ZERO);
			stat1_reg <= fsa_stat1_t'(WORD_ZERO);
			ques_reg <= fsa_ques_t'(QUES_PAD);
		end else begin
			stat0_reg <= stat0_next;
			stat1_reg <= stat1_next;
			ques_reg <= ques_next;
		end
	end

	// ----------------------------------------
	// Query answer path
	// ----------------------------------------
	// The answer path only reads the status registers, never writes them
	fsa_state_t state_reg, state_next;
	logic queryTake, idxBad, reqBad;
	logic [31:0] selWord, ansWord_next, hold_reg, ansWord_reg;
	logic ansValid_reg, ansLast_reg, ansError_reg, queryReady_reg;

	assign queryTake = queryValid && (state_reg == ST_IDLE);
	assign idxBad = (querySel == QS_INDEX) && (queryIndex > IDX_W'(1));
	assign reqBad = idxBad || (querySel == QS_RSVD);

	always_comb begin
		case (querySel)
			QS_QUES: selWord = {QUES_PAD, ques_reg};
			QS_INDEX: selWord = (queryIndex == '0) ? 32'(stat0_reg) : 32'(stat1_reg);
			QS_BOTH: selWord = stat0_reg;
			default: selWord = WORD_ZERO;
		endcase
	end

	assign ansWord_next = (state_reg == ST_SECOND) ? hold_reg : selWord;

	always_comb begin
		case (state_reg)
			ST_IDLE: state_next = (queryTake && querySel == QS_BOTH) ? ST_SECOND : ST_IDLE;
			ST_SECOND: state_next = ST_IDLE;
			default: state_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			hold_reg <= WORD_ZERO;
			ansWord_reg <= WORD_ZERO;
			ansValid_reg <= 1'b0;
			ansLast_reg <= 1'b0;
			ansError_reg <= 1'b0;
			queryReady_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			// Word 1 is captured with word 0 so the pair is one snapshot
			if (queryTake && querySel == QS_BOTH)
				hold_reg <= stat1_reg;
			ansWord_reg <= ansWord_next;
			ansValid_reg <= (queryTake && !reqBad) || (state_reg == ST_SECOND);
			ansLast_reg <= (queryTake && !reqBad && querySel != QS_BOTH) || (state_reg == ST_SECOND);
			ansError_reg <= queryTake && reqBad;
			queryReady_reg <= (state_next == ST_IDLE);
		end
	end

	assign queryReady = queryReady_reg;
	assign ansValid = ansValid_reg;
	assign ansLast = ansLast_reg;
	assign ansError = ansError_reg;
	assign ansWord = ansWord_reg;
	assign quesWord = ques_reg;
	assign statWord0 = stat0_reg;
	assign statWord1 = stat1_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_soft_summary: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg.softFaultSummary == (ques_reg.softOvercurrent | ques_reg.softOvervoltage | ques_reg.softOverpower))
		else $error("soft fault summary wrong");

	chk_hard_summary: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg.hardFaultSummary == (ques_reg.hardOvervoltage | ques_reg.hardOvercurrent
		| ques_reg.hardOvertemp | ques_reg.senseLossFlag))
		else $error("hard fault summary wrong");

	chk_trip_shared: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[3:1] == stat0_reg[6:4] && ques_reg.interlockOpenFlag == stat0_reg.interlockOpenFlag)
		else $error("questionable and status word disagree");

	chk_spare_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		(stat0_reg & ~STAT0_USED) == WORD_ZERO && (stat1_reg & ~STAT1_USED) == WORD_ZERO)
		else $error("unassigned status bit set");

	chk_live_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
		$fell(s0Sync_reg.currentTripFlag) |=> !stat0_reg.currentTripFlag ##1 (!ques_reg.softFaultSummary
		|| $past(s0Sync_reg.currentTripFlag) || $past(s0Sync_reg.voltageTripFlag)
		|| $past(s0Sync_reg.powerTripFlag)))
		else $error("status bit did not drop with its source");

	chk_index_one: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_INDEX && queryIndex == IDX_W'(1)
		|=> ansValid_reg && ansLast_reg && ansWord_reg == $past(stat1_reg))
		else $error("index 1 did not return status word 1");

	chk_both_pair: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_BOTH
		|=> ansValid_reg && !ansLast_reg && ansWord_reg == $past(stat0_reg)
		##1 ansValid_reg && ansLast_reg && ansWord_reg == $past(stat1_reg, 2))
		else $error("both-word answer wrong");

	chk_bad_index: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && idxBad |=> ansError_reg && !ansValid_reg)
		else $error("out of range index not refused");

	chk_read_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && $stable(s0Sync_reg) && $stable(s1Sync_reg) && $stable(qSync_reg)
		|=> $stable(stat0_reg) && $stable(stat1_reg) && $stable(ques_reg))
		else $error("read disturbed a status word");

	// Word registers load from the sync stage, so bits compare with that stage one edge back or with stat0_reg
	chk_hard_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[0] == $past(qSync_reg.hardOvervoltage) && ques_reg[4] == $past(qSync_reg.hardOvercurrent)
		&& ques_reg[5] == $past(qSync_reg.hardOvertemp) && ques_reg[6] == stat0_reg[7])
		else $error("hard protection bit misplaced");

	chk_mode_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[7] == $past(qSync_reg.constCurrentMode) && ques_reg[8] == $past(qSync_reg.constVoltageMode)
		&& ques_reg[9] == $past(qSync_reg.constResistanceMode) && ques_reg[10] == $past(qSync_reg.constPowerMode))
		else $error("regulation mode bit misplaced");

	chk_system_bits: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[13] == stat0_reg[20] && ques_reg[14] == $past(qSync_reg.inputPowerLossFlag)
		&& ques_reg[15] == $past(qSync_reg.ioInputFaultFlag))
		else $error("system condition bit misplaced");

	chk_soft_source: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[11] == ($past(s0Sync_reg.currentTripFlag) | $past(s0Sync_reg.voltageTripFlag)
		| $past(s0Sync_reg.powerTripFlag)))
		else $error("soft summary does not follow its trips");

	chk_hard_source: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ques_reg[12] == ($past(qSync_reg.hardOvervoltage) | $past(qSync_reg.hardOvercurrent)
		| $past(qSync_reg.hardOvertemp) | $past(s0Sync_reg.senseLossStatus)))
		else $error("hard summary does not follow its protections");

	chk_live_word0: assert property (@(posedge sys_clk) disable iff (!arst_n)
		stat0_reg == ($past(s0Sync_reg) & STAT0_USED))
		else $error("status word 0 not sampled from its sources");

	chk_live_word1: assert property (@(posedge sys_clk) disable iff (!arst_n)
		stat1_reg == ($past(s1Sync_reg) & STAT1_USED))
		else $error("status word 1 not sampled from its sources");

	chk_index_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_INDEX && queryIndex == '0
		|=> ansValid_reg && ansLast_reg && ansWord_reg == $past(stat0_reg))
		else $error("index 0 did not return status word 0");

	chk_ques_answer: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_QUES
		|=> ansValid_reg && ansLast_reg && ansWord_reg == {QUES_PAD, $past(ques_reg)})
		else $error("questionable answer wrong");

	chk_reserved_sel: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_RSVD |=> ansError_reg && !ansValid_reg)
		else $error("reserved select not refused");

	chk_both_busy: assert property (@(posedge sys_clk) disable iff (!arst_n)
		queryTake && querySel == QS_BOTH |=> !queryReady_reg ##1 queryReady_reg)
		else $error("ready wrong around a both-word answer");

	chk_second_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
		state_reg == ST_SECOND |=> ansValid_reg && ansLast_reg && !ansError_reg)
		else $error("request taken during second word");

	chk_no_unasked: assert property (@(posedge sys_clk) disable iff (!arst_n)
		!queryTake && state_reg != ST_SECOND |=> !ansValid_reg && !ansError_reg)
		else $error("answer without a request");

	chk_last_valid: assert property (@(posedge sys_clk) disable iff (!arst_n)
		ansLast_reg |-> ansValid_reg)
		else $error("last flag without a word");

endmodule : fsa_fault_status
`default_nettype wire

//--- testbench/test_fault_status_aggregator.sv
// Purpose: Self-checking bench for the fault status aggregator.
// Assumes: Sources are held for 3 or more clocks before any read or query.
// Notes: Expected words are rebuilt from the bit layout, never read back from the design.
`timescale 1ns/10ps
`default_nettype none
module test_fault_status_aggregator import fsa_pkg::*;;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	localparam logic [31:0] S0_MASK = 32'h7FDF_FFF3;
	localparam logic [31:0] S1_MASK = 32'h0003_00F7;
	localparam int LIMIT = 5000;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	fsa_stat0_t stat0Src = '0;
	fsa_stat1_t stat1Src = '0;
	fsa_qsrc_t quesSrc = '0;
	logic queryValid = 1'b0;
	fsa_qsel_t querySel = QS_QUES;
	logic [7:0] queryIndex = 8'h00;
	logic queryReady;
	logic ansValid;
	logic ansLast;
	logic ansError;
	logic [31:0] ansWord;
	fsa_ques_t quesWord;
	fsa_stat0_t statWord0;
	fsa_stat1_t statWord1;
	// Each note is {error, valid, last, word}
	logic [34:0] note[$];
	logic [34:0] expA;
	logic [34:0] gotA;
	logic [72:0] oneHot;
	logic lastBoth = 1'b0;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	integer seed = 32'h889C_878D;

	always #12.5 sys_clk = ~sys_clk;

	fsa_fault_status #(.IDX_W(8)) DUT (.sys_clk(sys_clk), .arst_n(arst_n), .stat0Src(stat0Src),
		.stat1Src(stat1Src), .quesSrc(quesSrc), .queryValid(queryValid), .querySel(querySel),
		.queryIndex(queryIndex), .queryReady(queryReady), .ansValid(ansValid), .ansLast(ansLast),
		.ansError(ansError), .ansWord(ansWord), .quesWord(quesWord), .statWord0(statWord0),
		.statWord1(statWord1));

	// ----------------------------------------
	// Reference model and helpers
	// ----------------------------------------
	function automatic fsa_ques_t ques_of(input fsa_stat0_t a, input fsa_qsrc_t q);
		fsa_ques_t r;
		r = '0;
		r.hardOvervoltage = q.hardOvervoltage;
		r.hardOvercurrent = q.hardOvercurrent;
		r.hardOvertemp = q.hardOvertemp;
		r.senseLossFlag = a.senseLossStatus;
		r.softOvercurrent = a.currentTripFlag;
		r.softOvervoltage = a.voltageTripFlag;
		r.softOverpower = a.powerTripFlag;
		r.constCurrentMode = q.constCurrentMode;
		r.constVoltageMode = q.constVoltageMode;
		r.constResistanceMode = q.constResistanceMode;
		r.constPowerMode = q.constPowerMode;
		r.softFaultSummary = r.softOvercurrent | r.softOvervoltage | r.softOverpower;
		r.hardFaultSummary = r.hardOvervoltage | r.hardOvercurrent | r.hardOvertemp | r.senseLossFlag;
		r.interlockOpenFlag = a.interlockOpenFlag;
		r.inputPowerLossFlag = q.inputPowerLossFlag;
		r.ioInputFaultFlag = q.ioInputFaultFlag;
		return r;
	endfunction : ques_of

	task automatic check(input logic [34:0] seen, input logic [34:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	task automatic live();
		check(35'(quesWord), 35'(ques_of(stat0Src, quesSrc)));
		check(35'(statWord0), 35'(stat0Src & S0_MASK));
		check(35'(statWord1), 35'(stat1Src & S1_MASK));
	endtask : live

	// Three edges of sync plus register before the words show the new sources
	task automatic settle(input logic [31:0] a, input logic [31:0] b, input logic [8:0] q);
		@(negedge sys_clk);
		stat0Src = a;
		stat1Src = b;
		quesSrc = q;
		repeat (3) @(negedge sys_clk);
		live();
	endtask : settle

	// Valid stays high between calls; a request seen while not ready is dropped silently
	task automatic ask(input fsa_qsel_t sel, input logic [7:0] idx);
		@(negedge sys_clk);
		queryValid = 1'b1;
		querySel = sel;
		queryIndex = idx;
		check(35'(queryReady), 35'(!lastBoth));
		lastBoth = (sel == QS_BOTH) && (queryReady === 1'b1);
		if (queryReady === 1'b1) begin
			if (sel == QS_QUES)
				note.push_back({3'b011, 16'h0000, ques_of(stat0Src, quesSrc)});
			else if (sel == QS_BOTH) begin
				note.push_back({3'b010, stat0Src & S0_MASK});
				note.push_back({3'b011, stat1Src & S1_MASK});
			end else if (sel == QS_INDEX && idx == 8'h00)
				note.push_back({3'b011, stat0Src & S0_MASK});
			else if (sel == QS_INDEX && idx == 8'h01)
				note.push_back({3'b011, stat1Src & S1_MASK});
			else
				note.push_back({3'b100, 32'h0000_0000});
		end
	endtask : ask

	// ----------------------------------------
	// Answer monitor and hang guard
	// ----------------------------------------
	always @(negedge sys_clk) begin
		if (ansValid === 1'b1 || ansError === 1'b1) begin
			gotA = {ansError, ansValid, ansLast, ansWord};
			if (note.size() == 0) begin
				failures++;
				$display("CHECK FAILED at %0t: answer with nothing pending", $time);
			end else begin
				expA = note.pop_front();
				if (expA[34])
					gotA[31:0] = 32'h0000_0000;
				check(gotA, expA);
			end
		end
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			failures++;
			$display("CHECK FAILED at %0t: run did not finish", $time);
			wrap_up();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		// Walking one: each assigned source lands on its own bit, spare inputs on none, and clears again when the next is set
		for (int i = 0; i < 73; i++) begin
			oneHot = 73'h1 << i;
			settle(oneHot[72:41], oneHot[40:9], oneHot[8:0]);
		end
		for (int i = 0; i < 40; i++) begin
			settle(32'($random(seed)), 32'($random(seed)), 9'($random(seed)));
			ask(QS_QUES, 8'h00);
			ask(QS_INDEX, 8'h00);
			ask(QS_INDEX, 8'h01);
			ask(QS_BOTH, 8'h00);
			ask(QS_INDEX, 8'h01);
			ask(QS_RSVD, 8'h00);
			ask(QS_INDEX, 8'h02);
			ask(QS_INDEX, 8'($random(seed)));
			@(negedge sys_clk);
			queryValid = 1'b0;
			repeat (3) @(negedge sys_clk);
			live();
		end
		check(35'(note.size()), 35'h0_0000_0000);
		wrap_up();
	end
endmodule : test_fault_status_aggregator
`default_nettype wire
